// ==== scfs_defs.vh ====
// scfs_defs.vh: constants for the smartcard fault supervisor.
// assumes a 100 MHz system clock; included by the design file only.
`ifndef SCFS_DEFS_VH
`define SCFS_DEFS_VH

// timing
`define SCFS_CLK_MHZ 100
`define SCFS_T_UNIT_NS 25000
`define SCFS_T_UNIT_CYC ((`SCFS_T_UNIT_NS * `SCFS_CLK_MHZ) / 1000)
`define SCFS_HALF_T_CYC (`SCFS_T_UNIT_CYC / 2)
`define SCFS_DEB_MS 8
`define SCFS_DEB_CYC (`SCFS_DEB_MS * 1000 * 1000 * `SCFS_CLK_MHZ / 1000)
`define SCFS_POR_CYC 20'h10
`define SCFS_CNT_W 20

// register map, byte addresses
`define SCFS_ADDR_W 4
`define SCFS_A_CTRL 4'h0
`define SCFS_A_STAT 4'h4
`define SCFS_A_IRQ_ST 4'h8
`define SCFS_A_IRQ_MASK 4'hc

// fault/event bit positions
`define SCFS_EV_W 6
`define SCFS_EV_OVL 0
`define SCFS_EV_REM 1
`define SCFS_EV_SUP 2
`define SCFS_EV_CONV 3
`define SCFS_EV_HOT 4
`define SCFS_EV_INS 5

// supply select codes
`define SCFS_VSEL_3V 2'h0
`define SCFS_VSEL_5V 2'h1
`define SCFS_VSEL_1V8 2'h2

// deactivation steps
`define SCFS_DS_STEP_W 3
`endif

// ==== scfs_fault_supervisor.v ====
// scfs_fault_supervisor.v: fault monitor, debounce, emergency deactivation
// sequencer and card supply select for a smartcard interface.
// assumes one 100 MHz clock; all analog detector inputs and pins are async.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`include "scfs_defs.vh"

// debounce length defaults to the full filter time; a bench may shorten it
module scfs_fault_supervisor #(
  parameter [`SCFS_CNT_W-1:0] DEB_CYC = `SCFS_DEB_CYC // debounce length in clock cycles
) (
  input wire clock, // system clock, 100 MHz
  input wire rstn, // async reset, active low
  input wire session_request_n, // host session request, active low
  input wire card_detect, // card presence contact, high = present
  input wire low_voltage_select, // 1.8 V select
  input wire high_mid_select, // 5 V / 3 V select
  input wire overload_det, // card supply overcurrent or short
  input wire supply_drop_det, // host supply below threshold
  input wire converter_fault_det, // step-up converter out of range
  input wire overheat_det, // die overtemperature
  input wire [3:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  output reg fault_status_n, // multiplexed fault/presence status, active low
  output reg card_power_on, // card supply enabled
  output reg [1:0] vcc_select, // card supply level code
  output reg card_rst_en, // card reset released
  output reg card_clk_en, // card clock running
  output reg card_io_en, // data lines enabled (else pulled low)
  output reg por_pulse, // internal power-on reset pulse
  output reg irq // level interrupt
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ACTIVE = 3'h1;
  localparam ST_DEACT = 3'h2;
  localparam ST_HOLD = 3'h3;

  // ********************************************************
  // shared decoders
  // ********************************************************
  // register address match, used by every write strobe
  function reg_hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      reg_hit = (addr == target);
    end
  endfunction

  // supply level code; the low voltage select has priority
  function [1:0] vsel_code;
    input lv;
    input hm;
    begin
      if (lv) begin
        vsel_code = `SCFS_VSEL_1V8;
      end else if (hm) begin
        vsel_code = `SCFS_VSEL_5V;
      end else begin
        vsel_code = `SCFS_VSEL_3V;
      end
    end
  endfunction

  wire wr_ctrl = reg_wr & reg_hit(reg_addr, `SCFS_A_CTRL);
  wire wr_irq = reg_wr & reg_hit(reg_addr, `SCFS_A_IRQ_ST);
  wire wr_mask = reg_wr & reg_hit(reg_addr, `SCFS_A_IRQ_MASK);

  // ********************************************************
  // input synchronisers
  // ********************************************************
  localparam NSYNC = 8;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] meta_r;
  reg [NSYNC-1:0] sync_r;
  assign async_in = {converter_fault_det, overheat_det, supply_drop_det, overload_det,
                     high_mid_select, low_voltage_select, card_detect, session_request_n};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          meta_r[gi] <= (gi == 0) ? 1'b1 : 1'b0;
          sync_r[gi] <= (gi == 0) ? 1'b1 : 1'b0;
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
  wire req_s = ~sync_r[0];
  wire card_detect_s = sync_r[1];
  wire lv_s = sync_r[2];
  wire hm_s = sync_r[3];
  wire ovl_s = sync_r[4];
  wire sup_s = sync_r[5];
  wire hot_s = sync_r[6];
  wire conv_s = sync_r[7];

  // ********************************************************
  // presence debounce
  // ********************************************************
  reg present_r;
  reg [`SCFS_CNT_W-1:0] deb_cnt_r;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      present_r <= 1'b0;
      deb_cnt_r <= {`SCFS_CNT_W{1'b0}};
    end else if (!card_detect_s) begin
      present_r <= 1'b0;
      deb_cnt_r <= {`SCFS_CNT_W{1'b0}};
    end else if (!present_r) begin
      if (deb_cnt_r == DEB_CYC - 1'b1) begin
        present_r <= 1'b1;
      end else begin
        deb_cnt_r <= deb_cnt_r + 1'b1;
      end
    end
  end

  // ********************************************************
  // fault detection and sequencer
  // ********************************************************
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`SCFS_CNT_W-1:0] seq_cnt_r;
  reg sup_d_r;
  reg [`SCFS_CNT_W-1:0] por_cnt_r;
  wire in_session = (state_r == ST_ACTIVE);
  wire [`SCFS_EV_W-1:0] ev_raw = {1'b0, hot_s, conv_s, sup_s, ~present_r, ovl_s};
  wire any_fault = |ev_raw[`SCFS_EV_HOT:`SCFS_EV_OVL];

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (req_s && present_r) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (any_fault || !req_s) begin
          state_nxt = ST_DEACT;
        end
      end
      ST_DEACT: begin
        if (seq_cnt_r == `SCFS_HALF_T_CYC * 3 - 1) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!req_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      seq_cnt_r <= {`SCFS_CNT_W{1'b0}};
      card_power_on <= 1'b0;
      card_rst_en <= 1'b0;
      card_clk_en <= 1'b0;
      card_io_en <= 1'b0;
      fault_status_n <= 1'b0;
    end else begin
      state_r <= state_nxt;
      seq_cnt_r <= (state_r == ST_DEACT) ? seq_cnt_r + 1'b1 : {`SCFS_CNT_W{1'b0}};
      case (state_nxt)
        ST_ACTIVE: begin
          card_power_on <= 1'b1;
          card_io_en <= 1'b1;
          card_clk_en <= 1'b1;
          card_rst_en <= 1'b1;
          fault_status_n <= 1'b1;
        end
        ST_DEACT: begin
          card_rst_en <= 1'b0;
          if (seq_cnt_r >= `SCFS_HALF_T_CYC - 1) begin
            card_clk_en <= 1'b0;
          end
          if (seq_cnt_r >= `SCFS_T_UNIT_CYC - 1) begin
            card_io_en <= 1'b0;
          end
          if (any_fault) begin
            fault_status_n <= 1'b0;
          end
        end
        ST_HOLD: begin
          card_power_on <= 1'b0;
          card_clk_en <= 1'b0;
          card_io_en <= 1'b0;
          if (!req_s) begin
            fault_status_n <= present_r;
          end
        end
        default: begin
          card_power_on <= 1'b0;
          card_rst_en <= 1'b0;
          card_clk_en <= 1'b0;
          card_io_en <= 1'b0;
          fault_status_n <= present_r;
        end
      endcase
    end
  end

  // ********************************************************
  // supply-drop reset pulse outside a session
  // ********************************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sup_d_r <= 1'b0;
      por_cnt_r <= {`SCFS_CNT_W{1'b0}};
      por_pulse <= 1'b0;
    end else begin
      sup_d_r <= sup_s;
      if (sup_s && !sup_d_r && !in_session) begin
        por_cnt_r <= `SCFS_POR_CYC;
      end else if (por_cnt_r != {`SCFS_CNT_W{1'b0}}) begin
        por_cnt_r <= por_cnt_r - 1'b1;
      end
      por_pulse <= (por_cnt_r != {`SCFS_CNT_W{1'b0}});
    end
  end

  // ********************************************************
  // supply select
  // ********************************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vcc_select <= `SCFS_VSEL_3V;
    end else begin
      vcc_select <= vsel_code(lv_s, hm_s);
    end
  end

  // ********************************************************
  // registers and interrupt
  // ********************************************************
  reg [`SCFS_EV_W-1:0] irq_st_r;
  reg [`SCFS_EV_W-1:0] irq_mask_r;
  reg ctrl_irq_en_r;
  reg present_d_r;
  wire [`SCFS_EV_W-1:0] ev_set;
  // events latch only while in a session, except insertion
  assign ev_set = {present_r & ~present_d_r,
                   in_session ? ev_raw[`SCFS_EV_HOT:`SCFS_EV_OVL] : {(`SCFS_EV_W-1){1'b0}}};
  wire [`SCFS_EV_W-1:0] ev_clr = wr_irq ?
                                 reg_wdata[`SCFS_EV_W-1:0] : {`SCFS_EV_W{1'b0}};

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_st_r <= {`SCFS_EV_W{1'b0}};
      irq_mask_r <= {`SCFS_EV_W{1'b0}};
      ctrl_irq_en_r <= 1'b0;
      present_d_r <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      present_d_r <= present_r;
      irq_st_r <= (irq_st_r & ~ev_clr) | ev_set; // set wins over clear
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[`SCFS_EV_W-1:0];
      end
      if (wr_ctrl) begin
        ctrl_irq_en_r <= reg_wdata[0];
      end
      irq <= ctrl_irq_en_r & |(irq_st_r & irq_mask_r);
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `SCFS_A_CTRL: reg_rdata <= {31'h0, ctrl_irq_en_r};
          `SCFS_A_STAT: reg_rdata <= {24'h0, vcc_select, state_r, present_r, fault_status_n, req_s};
          `SCFS_A_IRQ_ST: reg_rdata <= {26'h0, irq_st_r};
          `SCFS_A_IRQ_MASK: reg_rdata <= {26'h0, irq_mask_r};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== scfs_fault_supervisor_props.sv ====
// scfs_fault_supervisor_props.sv: port assertions for the fault supervisor.
// assumes the bind at the foot attaches it to every supervisor instance.
module scfs_props (
  input wire clock, // clock
  input wire rstn, // reset
  input wire session_request_n, // request
  input wire card_detect, // presence
  input wire low_voltage_select, // 1.8 V
  input wire high_mid_select, // 5/3 V
  input wire overload_det, // overload
  input wire supply_drop_det, // drop
  input wire overheat_det, // heat
  input wire fault_status_n, // status
  input wire card_power_on, // power
  input wire [1:0] vcc_select, // level
  input wire card_rst_en, // reset en
  input wire card_clk_en, // clock en
  input wire card_io_en, // io en
  input wire por_pulse // por
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [12:0] cnt_r;
  logic rst_q_r;
  // cycles since card reset was pulled low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 13'h0;
      rst_q_r <= 1'b0;
    end else begin
      rst_q_r <= card_rst_en;
      cnt_r <= (rst_q_r && !card_rst_en) ? 13'h1 : cnt_r + {12'h0, ~&cnt_r};
    end
  end
  // ****************
  // assertions
  // ****************
  property p_v18; low_voltage_select [*4] |-> vcc_select == 2'h2; endproperty
  a_v18: assert property (p_v18) else $error("low level not chosen");
  property p_v53; (!low_voltage_select && $stable(high_mid_select)) [*4] |-> vcc_select == {1'b0, high_mid_select};
  endproperty
  a_v53: assert property (p_v53) else $error("supply level wrong");
  property p_flt; $rose(overload_det) && card_power_on && fault_status_n |-> ##[1:4] !fault_status_n ##[0:2] !card_rst_en;
  endproperty
  a_flt: assert property (p_flt) else $error("fault not acted on");
  property p_ext; $fell(card_detect) && card_power_on |-> ##[1:4] !fault_status_n ##[0:2] !card_rst_en; endproperty
  a_ext: assert property (p_ext) else $error("extraction not acted on");
  property p_clk; $fell(card_clk_en) |-> cnt_r >= 13'h4e0 && cnt_r <= 13'h4e4; endproperty
  a_clk: assert property (p_clk) else $error("clock stop off time");
  property p_io; $fell(card_io_en) |-> cnt_r >= 13'h9c2 && cnt_r <= 13'h9c6; endproperty
  a_io: assert property (p_io) else $error("data stop off time");
  property p_quiet; $rose(overheat_det) && session_request_n && !card_power_on |-> $stable(fault_status_n) [*6]; endproperty
  a_quiet: assert property (p_quiet) else $error("idle fault reported");
  property p_por; $rose(supply_drop_det) && session_request_n && !card_power_on |-> ##[2:5] por_pulse; endproperty
  a_por: assert property (p_por) else $error("no reset pulse");
  property p_idle; (!card_detect && session_request_n) [*8] |-> !fault_status_n; endproperty
  a_idle: assert property (p_idle) else $error("absent card shown");
  property p_ins; $rose(card_detect) && session_request_n |-> !fault_status_n [*8]; endproperty
  a_ins: assert property (p_ins) else $error("status rose early");
  c_fault: cover property (!fault_status_n && card_power_on);
  c_ext: cover property ($fell(card_detect) && card_power_on);
  c_por: cover property (por_pulse);
endmodule

bind scfs_fault_supervisor scfs_props u_props (.clock, .rstn, .session_request_n, .card_detect, .low_voltage_select,
  .high_mid_select, .overload_det, .supply_drop_det, .overheat_det, .fault_status_n, .card_power_on, .vcc_select,
  .card_rst_en, .card_clk_en, .card_io_en, .por_pulse);

// ==== scfs_host_model.sv ====
// scfs_host_model.sv: host controller model driving the session request.
// assumes the bench raises go for a session and drops it once a fault shows.
module scfs_host_model (
  input wire clock, // clock
  input wire rstn, // reset
  input wire go, // session wanted
  input wire slow, // late release
  input wire fault_status_n, // status in
  input wire card_power_on, // card powered
  output logic session_request_n, // request out
  output logic seen_n // status read after a session
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_r;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      session_request_n <= 1'b1;
      seen_n <= 1'b0;
      wait_r <= 0;
    end else if (session_request_n) begin
      wait_r <= 0;
      session_request_n <= !go;
      if (!card_power_on) seen_n <= fault_status_n;
    end else if (!go || !fault_status_n) begin
      wait_r <= wait_r + 1;
      if (wait_r == (slow ? 5000 : 2)) session_request_n <= 1'b1;
    end
  end
endmodule

// ==== scfs_fault_supervisor_test.sv ====
// scfs_fault_supervisor_test.sv: top bench for the fault supervisor.
// assumes the host model and the checker are compiled before it.
module scfs_fault_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, card_detect = 0, low_voltage_select = 0, high_mid_select = 0;
  logic overload_det = 0, supply_drop_det = 0, overheat_det = 0, go = 0, slow = 0, reg_wr = 0, reg_rd = 0;
  logic converter_fault_det = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic session_request_n, fault_status_n, card_power_on, card_rst_en, card_clk_en, card_io_en, por_pulse, irq, seen_n;
  logic [1:0] vcc_select;
  int err_count = 0, cmp_count = 0, i;
  scfs_fault_supervisor #(.DEB_CYC(20'h00320)) dut (.clock, .rstn, .session_request_n, .card_detect,
    .low_voltage_select, .high_mid_select,
    .overload_det, .supply_drop_det, .converter_fault_det, .overheat_det, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .fault_status_n, .card_power_on, .vcc_select, .card_rst_en, .card_clk_en, .card_io_en,
    .por_pulse, .irq);
  scfs_host_model host (.clock, .rstn, .go, .slow, .fault_status_n, .card_power_on, .session_request_n, .seen_n);
  initial forever #5 clock = ~clock;
  task automatic end_sim;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic till(ref logic s, input logic v, input int n);
    while (s !== v) begin
      if (n-- == 0) begin
        err_count++;
        end_sim();
      end
      @(posedge clock);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge clock);
  endtask
  function automatic logic [1:0] ev(input logic l, input logic h);
    return l ? 2'h2 : {1'b0, h};
  endfunction
  initial begin
    void'($urandom(32'h41638778));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (9) @(posedge clock);
    chk(fault_status_n, 1'b0);
    for (i = 0; i < 10; i++) begin
      {low_voltage_select, high_mid_select} <= 2'(i < 4 ? i : $urandom);
      repeat (5) @(posedge clock);
      chk(vcc_select, ev(low_voltage_select, high_mid_select));
    end
    card_detect <= 1'b1;
    repeat (790) @(posedge clock);
    chk(fault_status_n, 1'b0);
    till(fault_status_n, 1'b1, 2000);
    {supply_drop_det, overheat_det, overload_det} <= 3'h7;
    till(por_pulse, 1'b1, 10);
    repeat (5) @(posedge clock);
    chk(fault_status_n, 1'b1);
    {supply_drop_det, overheat_det, overload_det} <= 3'h0;
    wr(4'h0, 32'h1);
    wr(4'hc, 32'h3f);
    wr(4'h8, 32'h3f);
    chk(irq, 1'b0);
    rd(4'h8, 32'h0);
    rd(4'h2, 32'h0);
    slow <= 1'b1;
    go <= 1'b1;
    till(card_power_on, 1'b1, 100);
    {converter_fault_det, overload_det} <= 2'h3;
    till(fault_status_n, 1'b0, 6);
    go <= 1'b0;
    till(card_rst_en, 1'b0, 3);
    @(posedge clock);
    chk(irq, 1'b1);
    rd(4'h8, 32'h9);
    till(card_power_on, 1'b0, 5000);
    {converter_fault_det, overload_det} <= 2'h0;
    repeat (100) @(posedge clock);
    chk({card_power_on, fault_status_n, session_request_n}, 3'h0);
    till(session_request_n, 1'b1, 2000);
    repeat (8) @(posedge clock);
    chk(seen_n, 1'b1);
    wr(4'hc, 32'h0);
    chk(irq, 1'b0);
    wr(4'h8, 32'h3f);
    wr(4'hc, 32'h3f);
    chk(irq, 1'b0);
    slow <= 1'b0;
    go <= 1'b1;
    till(card_power_on, 1'b1, 100);
    card_detect <= 1'b0;
    till(fault_status_n, 1'b0, 6);
    go <= 1'b0;
    till(card_rst_en, 1'b0, 3);
    @(posedge clock);
    chk(irq, 1'b1);
    till(card_power_on, 1'b0, 5000);
    repeat (10) @(posedge clock);
    chk(seen_n, 1'b0);
    end_sim();
  end
endmodule
